// *** hdl/dssl_pkg.sv ***
// Constants and types shared by the stack limit checker and its address unit
package dssl_pkg;
  localparam int DATA_W = 16;
  localparam int PC_W = 23;
  localparam int SRL_W = 8;
  // Word step of the stack pointer
  localparam logic [15:0] WORD_STEP = 16'h0002;
  // Lowest legal stack address; below it lies register space
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  // Stack pointer value after reset
  localparam logic [15:0] SP_RST = 16'h0800;
  // Limit after reset: any value is legal, software must load it
  localparam logic [15:0] LIMIT_RST = 16'hfffe;
  // Default fixed start of the Y region in the combined space
  localparam logic [15:0] Y_BOUNDARY_DFLT = 16'h0900;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Push sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PC_HI = 1'b1
  } dssl_push_st_t;
  // Kind of word pushed
  typedef enum logic [1:0] {
    PK_DATA = 2'b00,
    PK_CALL = 2'b01,
    PK_EXC = 2'b10
  } dssl_push_kind_t;
endpackage

// *** hdl/dssl_agu_if.sv ***
// Request and result wires between the checker and its address unit
`timescale 1ns/1ps
`default_nettype none
interface dssl_agu_if;
  logic x_req;
  logic x_wr;
  logic [15:0] x_base;
  logic [15:0] x_step;
  logic x_mod;
  logic x_brev;
  logic y_req;
  logic [15:0] y_base;
  logic [15:0] y_step;
  logic y_mod;
  logic dsp;
  logic [15:0] mod_start;
  logic [15:0] mod_end;
  logic [15:0] brev_step;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic y_go;
  modport ctl (
    output x_req, x_wr, x_base, x_step, x_mod, x_brev,
    output y_req, y_base, y_step, y_mod, dsp,
    output mod_start, mod_end, brev_step,
    input x_ea, y_ea, y_go
  );
  modport agu (
    input x_req, x_wr, x_base, x_step, x_mod, x_brev,
    input y_req, y_base, y_step, y_mod, dsp,
    input mod_start, mod_end, brev_step,
    output x_ea, y_ea, y_go
  );
endinterface
`default_nettype wire

// *** hdl/dssl_agu.sv ***
// Combinational X and Y effective address generation
`timescale 1ns/1ps
`default_nettype none
module dssl_agu #(
  parameter logic [15:0] Y_BOUNDARY = dssl_pkg::Y_BOUNDARY_DFLT
) (
  dssl_agu_if.agu bus
);
  import dssl_pkg::*;

  // Mirror the bits of a word for reverse-carry addition
  function automatic logic [15:0] mirror(input logic [15:0] v);
    logic [15:0] r;
    r = ADDR_ZERO;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  wire [15:0] x_sum = bus.x_base + bus.x_step;
  wire [15:0] y_sum = bus.y_base + bus.y_step;
  wire x_fwd = ~bus.x_step[15];
  wire y_fwd = ~bus.y_step[15];
  // Modulo wrap at the buffer ends, both regions
  wire x_wrap_hi = bus.x_mod & x_fwd & (bus.x_base == bus.mod_end); // R13
  wire x_wrap_lo = bus.x_mod & ~x_fwd & (bus.x_base == bus.mod_start);
  wire y_wrap_hi = bus.y_mod & y_fwd & (bus.y_base == bus.mod_end); // R13
  wire y_wrap_lo = bus.y_mod & ~y_fwd & (bus.y_base == bus.mod_start);
  wire [15:0] x_mod_ea = x_wrap_hi ? bus.mod_start :
                         (x_wrap_lo ? bus.mod_end : x_sum);
  // Bit-reversed stepping only on writes into X
  wire brev_on = bus.x_brev & bus.x_wr; // R13
  wire [15:0] rev_sum = mirror(bus.x_base) + mirror(bus.brev_step);
  wire [15:0] x_brev_ea = mirror(rev_sum);

  assign bus.x_ea = brev_on ? x_brev_ea : x_mod_ea;
  assign bus.y_ea = y_wrap_hi ? bus.mod_start :
                    (y_wrap_lo ? bus.mod_end : y_sum);
  // Second read path only for the dual operand class, inside fixed Y
  assign bus.y_go = bus.y_req & bus.dsp & (bus.y_ea >= Y_BOUNDARY); // R16 R14
endmodule
`default_nettype wire

// *** hdl/dssl_stack_checker.sv ***
// Stack pointer, stack limit check and X/Y data bus steering
// How it works
// [R1] Register fifteen is stack pointer, grows upward
// [R2] Pop predecrements, push postincrements the pointer
// [R3] Call push clears the pushed counter MSb
// [R4] Exception push puts status byte above counter
// [R5] Limit register reset value is not defined
// [R6] Limit bit 0 always reads zero
// [R7] Every pointer-fifteen address compared with limit
// [R8] Push at limit passes, next one traps
// [R9] Address below 0x0800 raises underflow trap
// [R10] Software avoids stack read right after limit write
// [R11] Addresses are 16-bit byte pointers
// [R12] All writes use one combined linear space
// [R13] Modulo both regions; bit-reverse only X writes
// [R14] X/Y boundary fixed, not software settable
// [R15] X read bus serves combined and prefetch reads
// [R16] Y gives second read for dual operand class
// [R17] Trap request held until acknowledged
`timescale 1ns/1ps
`default_nettype none
module dssl_stack_checker #(
  parameter logic [15:0] Y_BOUNDARY = dssl_pkg::Y_BOUNDARY_DFLT
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic STK_PUSH_I,
  input wire logic STK_POP_I,
  input wire dssl_pkg::dssl_push_kind_t STK_PUSH_KIND_I,
  input wire logic [15:0] STK_DATA_I,
  input wire logic [dssl_pkg::PC_W-1:0] PC_I,
  input wire logic [dssl_pkg::SRL_W-1:0] STATUS_LOW_BYTE_I,
  input wire logic SP_WR_I,
  input wire logic [15:0] SP_DATA_I,
  input wire logic LIMIT_WR_I,
  input wire logic [15:0] LIMIT_DATA_I,
  input wire logic AGU_X_REQ_I,
  input wire logic AGU_X_WR_I,
  input wire logic AGU_X_PTR15_I,
  input wire logic [15:0] AGU_X_BASE_I,
  input wire logic [15:0] AGU_X_STEP_I,
  input wire logic AGU_X_MOD_I,
  input wire logic AGU_X_BREV_I,
  input wire logic [15:0] AGU_X_WDATA_I,
  input wire logic AGU_Y_REQ_I,
  input wire logic [15:0] AGU_Y_BASE_I,
  input wire logic [15:0] AGU_Y_STEP_I,
  input wire logic AGU_Y_MOD_I,
  input wire logic AGU_DSP_I,
  input wire logic [15:0] MOD_START_I,
  input wire logic [15:0] MOD_END_I,
  input wire logic [15:0] BREV_STEP_I,
  input wire logic STK_ERR_ACK_I,
  output var logic XWR_EN_O,
  output var logic [15:0] XWR_ADDR_O,
  output var logic [15:0] XWR_DATA_O,
  output var logic XRD_EN_O,
  output var logic [15:0] XRD_ADDR_O,
  output var logic YRD_EN_O,
  output var logic [15:0] YRD_ADDR_O,
  output var logic [15:0] SP_O,
  output var logic [15:0] STACK_LIMIT_O,
  output var logic STK_ERR_O,
  output var logic STK_OVF_O,
  output var logic STK_UNF_O,
  output var logic BUSY_O
);
  import dssl_pkg::*;

  dssl_push_st_t st;
  dssl_push_st_t next_st;
  logic [15:0] pc_hi_word;
  logic [15:0] next_pc_hi_word;

  dssl_agu_if agu_bus ();

  dssl_agu #(
    .Y_BOUNDARY(Y_BOUNDARY)
  ) u_agu (
    .bus(agu_bus.agu)
  );

  // Request acceptance: the second push word blocks new stack operations
  wire busy = (st == ST_PC_HI);
  wire do_push = STK_PUSH_I & ~busy;
  wire do_pop = STK_POP_I & ~busy & ~STK_PUSH_I;
  wire push_any = do_push | busy;
  wire stk_act = push_any | do_pop;
  wire pc_push = do_push & ((STK_PUSH_KIND_I == PK_CALL) |
                            (STK_PUSH_KIND_I == PK_EXC));

  // Upper word of a pushed program counter
  wire [23:0] pc_ext = {1'b0, PC_I};
  wire [15:0] call_hi = {BYTE_ZERO, pc_ext[23:16]}; // R3
  wire [15:0] exc_hi = {STATUS_LOW_BYTE_I, pc_ext[23:16]}; // R4
  wire exc_push = STK_PUSH_KIND_I == PK_EXC;
  wire [15:0] hi_word = exc_push ? exc_hi : call_hi;
  wire [15:0] lo_word = pc_push ? PC_I[15:0] : STK_DATA_I;
  wire [15:0] push_word = busy ? pc_hi_word : lo_word;

  // Stack addresses: push writes at the free word, pop reads below it
  wire [15:0] pop_ea = SP_O - WORD_STEP; // R2
  wire [15:0] push_sp = SP_O + WORD_STEP; // R1 R2
  wire [15:0] stk_ea = do_pop ? pop_ea : SP_O;

  // Address unit requests; stack operations own the X bus first
  assign agu_bus.x_req = AGU_X_REQ_I & ~stk_act;
  assign agu_bus.x_wr = AGU_X_WR_I;
  assign agu_bus.x_base = AGU_X_BASE_I;
  assign agu_bus.x_step = AGU_X_STEP_I;
  assign agu_bus.x_mod = AGU_X_MOD_I;
  assign agu_bus.x_brev = AGU_X_BREV_I;
  assign agu_bus.y_req = AGU_Y_REQ_I;
  assign agu_bus.y_base = AGU_Y_BASE_I;
  assign agu_bus.y_step = AGU_Y_STEP_I;
  assign agu_bus.y_mod = AGU_Y_MOD_I;
  assign agu_bus.dsp = AGU_DSP_I;
  assign agu_bus.mod_start = MOD_START_I;
  assign agu_bus.mod_end = MOD_END_I;
  assign agu_bus.brev_step = BREV_STEP_I;

  wire agu_x_go = agu_bus.x_req;
  wire agu_x_wr = agu_x_go & AGU_X_WR_I;
  wire agu_x_rd = agu_x_go & ~AGU_X_WR_I;

  // Limit check on every address formed from pointer fifteen
  wire chk_valid = stk_act | (agu_x_go & AGU_X_PTR15_I); // R7
  wire [15:0] chk_ea = stk_act ? stk_ea : agu_bus.x_ea;
  wire ovf_hit = chk_valid & (chk_ea > STACK_LIMIT_O); // R8
  wire unf_hit = chk_valid & (chk_ea < STACK_FLOOR); // R9

  // Write and read steering in the combined space
  wire next_xwr_en = push_any | agu_x_wr; // R12
  wire [15:0] next_xwr_addr = push_any ? SP_O : agu_bus.x_ea; // R11
  wire [15:0] next_xwr_data = push_any ? push_word : AGU_X_WDATA_I;
  wire next_xrd_en = do_pop | agu_x_rd; // R15
  wire [15:0] next_xrd_addr = do_pop ? pop_ea : agu_bus.x_ea; // R15

  // Pointer update; stack traffic outranks a direct pointer write
  wire [15:0] sp_wr_val = {SP_DATA_I[15:1], 1'b0};
  wire [15:0] next_sp = push_any ? push_sp :
                        (do_pop ? pop_ea :
                        (SP_WR_I ? sp_wr_val : SP_O)); // R1

  // Trap request: a new hit wins over a same-cycle acknowledge
  wire next_err = ovf_hit | unf_hit | (STK_ERR_O & ~STK_ERR_ACK_I); // R17
  wire next_ovf = ovf_hit | (STK_OVF_O & ~STK_ERR_ACK_I);
  wire next_unf = unf_hit | (STK_UNF_O & ~STK_ERR_ACK_I);

  // Push sequencer: a counter push takes two words, low then high
  always_comb begin
    next_st = st;
    next_pc_hi_word = pc_hi_word;
    unique case (st)
      ST_IDLE: begin
        if (pc_push) begin
          next_st = ST_PC_HI;
          next_pc_hi_word = hi_word;
        end
      end
      ST_PC_HI: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st <= ST_IDLE;
      pc_hi_word <= ADDR_ZERO;
      BUSY_O <= 1'b0;
    end else begin
      st <= next_st;
      pc_hi_word <= next_pc_hi_word;
      BUSY_O <= (next_st == ST_PC_HI);
    end
  end

  // Stack pointer and limit registers
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SP_O <= SP_RST;
      STACK_LIMIT_O <= LIMIT_RST; // R5
    end else begin
      SP_O <= next_sp;
      if (LIMIT_WR_I) begin
        STACK_LIMIT_O <= {LIMIT_DATA_I[15:1], 1'b0}; // R6
      end
    end
  end

  // Data bus outputs
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      XWR_EN_O <= 1'b0;
      XWR_ADDR_O <= ADDR_ZERO;
      XWR_DATA_O <= ADDR_ZERO;
      XRD_EN_O <= 1'b0;
      XRD_ADDR_O <= ADDR_ZERO;
      YRD_EN_O <= 1'b0;
      YRD_ADDR_O <= ADDR_ZERO;
    end else begin
      XWR_EN_O <= next_xwr_en;
      XWR_ADDR_O <= next_xwr_addr;
      XWR_DATA_O <= next_xwr_data;
      XRD_EN_O <= next_xrd_en;
      XRD_ADDR_O <= next_xrd_addr;
      YRD_EN_O <= agu_bus.y_go; // R16
      YRD_ADDR_O <= agu_bus.y_ea;
    end
  end

  // Stack error trap request and its cause flags
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      STK_ERR_O <= 1'b0;
      STK_OVF_O <= 1'b0;
      STK_UNF_O <= 1'b0;
    end else begin
      STK_ERR_O <= next_err; // R17
      STK_OVF_O <= next_ovf;
      STK_UNF_O <= next_unf;
    end
  end
endmodule
`default_nettype wire

// *** test/dssl_chk_sva.sv ***
// Port assertions for the stack limit checker
`timescale 1ns/1ps
`default_nettype none
module dssl_chk (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic STK_PUSH_I,
  input wire logic STK_POP_I,
  input wire dssl_pkg::dssl_push_kind_t STK_PUSH_KIND_I,
  input wire logic [22:0] PC_I,
  input wire logic [7:0] STATUS_LOW_BYTE_I,
  input wire logic STK_ERR_ACK_I,
  input wire logic XWR_EN_O,
  input wire logic [15:0] XWR_ADDR_O,
  input wire logic [15:0] XWR_DATA_O,
  input wire logic XRD_EN_O,
  input wire logic [15:0] XRD_ADDR_O,
  input wire logic [15:0] SP_O,
  input wire logic [15:0] STACK_LIMIT_O,
  input wire logic STK_ERR_O,
  input wire logic STK_OVF_O,
  input wire logic STK_UNF_O,
  input wire logic BUSY_O
);
  import dssl_pkg::*;
  wire push_t;
  wire pop_t;
  // Stack requests the block accepts
  assign push_t = STK_PUSH_I && !BUSY_O;
  assign pop_t = STK_POP_I && !STK_PUSH_I && !BUSY_O;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  chk_push_post_inc: assert property (
    push_t |=> XWR_EN_O && XWR_ADDR_O == $past(SP_O)
    && SP_O == $past(SP_O) + WORD_STEP) else $error("push slot wrong");
  chk_pop_pre_dec: assert property (
    pop_t |=> XRD_EN_O && XRD_ADDR_O == $past(SP_O) - WORD_STEP
    && SP_O == XRD_ADDR_O) else $error("pop slot wrong");
  chk_call_msb_clear: assert property (
    push_t && STK_PUSH_KIND_I == PK_CALL |=> BUSY_O ##1 XWR_EN_O
    && XWR_DATA_O == {9'h000, $past(PC_I[22:16], 2)})
    else $error("call high word wrong");
  chk_exc_status_top: assert property (
    push_t && STK_PUSH_KIND_I == PK_EXC |=> BUSY_O ##1 XWR_EN_O
    && XWR_DATA_O == {$past(STATUS_LOW_BYTE_I, 2), 1'b0,
    $past(PC_I[22:16], 2)}) else $error("exception high word wrong");
  chk_limit_lsb_zero: assert property (
    STACK_LIMIT_O[0] == 1'b0) else $error("limit bit 0 set");
  chk_push_over: assert property (
    push_t && SP_O > STACK_LIMIT_O |=> STK_ERR_O && STK_OVF_O)
    else $error("overflow not trapped");
  chk_push_at_limit: assert property (
    push_t && !STK_ERR_O && SP_O == STACK_LIMIT_O && SP_O >= STACK_FLOOR
    |=> !STK_ERR_O) else $error("push at limit trapped");
  chk_pop_under: assert property (
    pop_t && (SP_O - WORD_STEP) < STACK_FLOOR |=> STK_ERR_O && STK_UNF_O)
    else $error("underflow not trapped");
  chk_trap_held: assert property (
    STK_ERR_O && !STK_ERR_ACK_I |=> STK_ERR_O) else $error("trap dropped");
  // Main scenarios reached
  cover property (push_t && SP_O == STACK_LIMIT_O);
  cover property (STK_ERR_O && STK_ERR_ACK_I);
  cover property (BUSY_O);
endmodule
`default_nettype wire

// *** test/dssl_exc_model.sv ***
// Exception logic model that answers a stack trap request
`timescale 1ns/1ps
`default_nettype none
module dssl_exc_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic trap_i,
  input wire logic [3:0] lat_i,
  output logic ack_o
);
  logic [3:0] cnt;
  // Wait lat_i cycles with the trap up, then acknowledge once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= trap_i && !ack_o && cnt == lat_i;
      cnt <= (trap_i && cnt != lat_i) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the stack limit checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  import dssl_pkg::*;
  logic clk = 0, rst_n = 0, push = 0, pop = 0, spwr = 0, lwr = 0, ack;
  logic xreq = 0, xp15 = 0, xmod = 0, yreq = 0, dsp = 0;
  logic xwr = 1'b0, xbrev = 1'b0;
  dssl_push_kind_t kind = PK_DATA;
  logic [15:0] spd = '0, ld = '0, xb = '0, xs = '0, sd = 16'h1234;
  logic [15:0] xwd = '0, bstep = '0;
  logic [22:0] pc = '0;
  logic [7:0] stb = '0;
  logic [3:0] lat = 4'h6;
  logic wen, ren, err, ovf, unf, busy, yen;
  logic [15:0] wa, wd, ra, ya, sp, lim;
  int error_cnt = 0, checks = 0;
  always #5 clk = ~clk;
  dssl_exc_model u_exc (.clk_i(clk), .rst_n_i(rst_n), .trap_i(err),
    .lat_i(lat), .ack_o(ack));
  dssl_stack_checker uut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .STK_PUSH_I(push), .STK_POP_I(pop), .STK_PUSH_KIND_I(kind),
    .STK_DATA_I(sd), .PC_I(pc), .STATUS_LOW_BYTE_I(stb), .SP_WR_I(spwr),
    .SP_DATA_I(spd), .LIMIT_WR_I(lwr), .LIMIT_DATA_I(ld),
    .AGU_X_REQ_I(xreq), .AGU_X_WR_I(xwr), .AGU_X_PTR15_I(xp15),
    .AGU_X_BASE_I(xb), .AGU_X_STEP_I(xs), .AGU_X_MOD_I(xmod),
    .AGU_X_BREV_I(xbrev), .AGU_X_WDATA_I(xwd), .AGU_Y_REQ_I(yreq),
    .AGU_Y_BASE_I(16'h0a00), .AGU_Y_STEP_I(WORD_STEP), .AGU_Y_MOD_I(1'b0),
    .AGU_DSP_I(dsp), .MOD_START_I(16'h1000), .MOD_END_I(16'h1010),
    .BREV_STEP_I(bstep), .STK_ERR_ACK_I(ack), .XWR_EN_O(wen),
    .XWR_ADDR_O(wa), .XWR_DATA_O(wd), .XRD_EN_O(ren), .XRD_ADDR_O(ra),
    .YRD_EN_O(yen), .YRD_ADDR_O(ya), .SP_O(sp), .STACK_LIMIT_O(lim),
    .STK_ERR_O(err), .STK_OVF_O(ovf), .STK_UNF_O(unf), .BUSY_O(busy));
  task automatic conclude;
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One stack request, outputs settled on return
  task automatic stk(input logic p, o, input dssl_push_kind_t k);
    @(posedge clk) begin
      push <= p;
      pop <= o;
      kind <= k;
    end
    @(posedge clk) {push, pop} <= 2'b00;
    #1;
  endtask
  // Pointer and limit loads; one idle slot follows a limit load
  task automatic load(input logic s, input logic [15:0] v);
    @(posedge clk) {spwr, lwr, spd, ld} <= {s, !s, v, v};
    @(posedge clk) {spwr, lwr} <= 2'b00;
    #1;
  endtask
  task automatic wclr;
    for (int i = 0; i < 30 && err !== 1'b0; i++) @(posedge clk);
    #1 `CHK("trap clear", 1'b0, err)
  endtask
  task automatic xy(input logic [15:0] b, s, input logic m, d);
    @(posedge clk) {xreq, yreq, xp15, xb, xs, xmod, dsp} <= {3'h7, b, s, m, d};
    @(posedge clk) {xreq, yreq} <= 2'b00;
    #1;
  endtask
  task automatic t_over;
    load(1, 16'h09fc);
    load(0, 16'h09ff);
    `CHK("limit", 16'h09fe, lim)
    stk(1, 0, PK_DATA);
    `CHK("push addr", 16'h09fc, wa)
    `CHK("push data", 16'h1234, wd)
    stk(1, 0, PK_DATA);
    `CHK("at limit", 1'b0, err)
    stk(1, 0, PK_DATA);
    `CHK("ovf", 2'b11, {err, ovf})
    repeat (3) @(posedge clk);
    #1 `CHK("held", 1'b1, err)
    wclr();
  endtask
  task automatic t_popcall;
    load(0, 16'hfffe);
    stk(0, 1, PK_DATA);
    `CHK("pop addr", 16'h0a00, ra)
    `CHK("pop sp", 16'h0a00, sp)
    stk(1, 1, PK_DATA);
    `CHK("push wins", 16'h0a02, sp)
    @(posedge clk) pc <= 23'h7f1234;
    stk(1, 0, PK_CALL);
    `CHK("call lo", 17'h11234, {busy, wd})
    @(posedge clk) #1 `CHK("call hi", 16'h007f, wd)
    `CHK("call hi addr", 16'h0a04, wa)
    @(posedge clk) {pc, stb} <= {23'h05abcd, 8'ha5};
    stk(1, 0, PK_EXC);
    @(posedge clk) #1 `CHK("exc hi", 16'ha505, wd)
  endtask
  task automatic t_unf;
    lat <= 4'h0;
    load(1, 16'h0800);
    stk(0, 1, PK_DATA);
    `CHK("unf addr", 16'h07fe, ra)
    `CHK("unf", 2'b11, {err, unf})
    wclr();
  endtask
  task automatic t_xy;
    load(0, 16'h0ffe);
    xy(16'h1000, WORD_STEP, 0, 1);
    `CHK("x read", 17'h11002, {ren, ra})
    `CHK("ptr ovf", 1'b1, ovf)
    `CHK("y read", 17'h10a02, {yen, ya})
    wclr();
    xy(16'h1010, WORD_STEP, 1, 0);
    `CHK("x modulo", 16'h1000, ra)
    `CHK("y no dsp", 1'b0, yen)
    wclr();
  endtask
  // Reverse-carry step on an X write; the same mode is ignored on a read
  task automatic t_brev;
    @(posedge clk) begin
      {xreq, xwr, xbrev, xp15} <= 4'he;
      {xb, xs, bstep, xwd} <= {16'h1008, WORD_STEP, 16'h0008, 16'h5a5a};
    end
    @(posedge clk) xwr <= 1'b0;
    #1 `CHK("brev write", 33'h1_1004_5a5a, {wen, wa, wd})
    @(posedge clk) {xreq, xbrev} <= 2'b00;
    #1 `CHK("brev read", 18'h2100a, {ren, wen, ra})
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_over();
    t_popcall();
    t_unf();
    t_xy();
    t_brev();
    conclude();
  end
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule
bind dssl_stack_checker dssl_chk u_chk (.REF_CLK_I, .RESET_N_I,
  .STK_PUSH_I, .STK_POP_I, .STK_PUSH_KIND_I, .PC_I, .STATUS_LOW_BYTE_I,
  .STK_ERR_ACK_I, .XWR_EN_O, .XWR_ADDR_O, .XWR_DATA_O, .XRD_EN_O,
  .XRD_ADDR_O, .SP_O, .STACK_LIMIT_O, .STK_ERR_O, .STK_OVF_O, .STK_UNF_O,
  .BUSY_O);
`default_nettype wire
